// ---- rtl/ocl_regs.svh ----
// Command codes, field positions, reset values and timing counts
// Contract
// - Each device keeps own limit and comparator
// - Limit word linear, exponent resets to 11110b
// - Stack limits to 62A*N, phase to 23A
// - Out-of-range writes flag status, alert host
// - Hardware limit 1A steps 4-23A, round up
// - Writes below 8A accepted, under 4A->4A
// - Restore rounds to nearest 0.25A, max 23A
// - Stack write divides value among all phases
// - Stack read returns phase 0 times N
// - Phase write stores value to selected phase
// - Phase read returns selected phase value unscaled
// - Fault sets three status bits, alerts, responds
// - Action: ignore, invalid, delayed or immediate shutdown
// - Retry: latch off, 1-6 tries, or forever
// - Delay code sets shutdown clocks and hiccup
`ifndef OCL_REGS_SVH
`define OCL_REGS_SVH

`define CMD_FAULT_LIMIT 8'h46
`define CMD_FAULT_RESPONSE 8'h47
`define PHASE_ALL 8'hFF
`define MAX_PHASES 4
`define LIMIT_EXP_RST 5'h1E
`define LIMIT_RST_Q 7'h28
`define RESPONSE_RST 8'hC0
`define ACTION_MSB 7
`define ACTION_LSB 6
`define RETRY_MSB 5
`define RETRY_LSB 3
`define DELAY_MSB 2
`define DELAY_LSB 0
`define RETRY_FOREVER 3'h7
`define PHASE_MAX_Q 11'h05C
`define STACK_MAX_Q_PER 11'h0F8
`define HW_MIN_A 5'h04
`define CLK_MHZ 40
`define TON_RISE_US 1000
`define DELAY_SHORT_PWM 3'h1
`define DELAY_MID_PWM 3'h3
`define DELAY_LONG_PWM 3'h7

`endif

// ---- rtl/ocl_pkg.sv ----
// Types shared by the overcurrent limit and response logic
package ocl_pkg;
  typedef enum logic [1:0] {
    act_ignore,
    act_invalid,
    act_delayed,
    act_immediate
  } fault_action_e;
  typedef enum logic [2:0] {
    st_off,
    st_run,
    st_delay,
    st_hiccup,
    st_restart,
    st_latched
  } resp_state_e;
  typedef logic [6:0] phase_limit_t;
endpackage

// ---- rtl/overcurrent_fault_limit_response.sv ----
// Overcurrent fault limit and fault response command logic
`include "ocl_regs.svh"

module overcurrent_fault_limit_response
  import ocl_pkg::*;
#(
  parameter int TON_RISE_CYCLES = `TON_RISE_US * `CLK_MHZ
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Command port from the bus slave
  input wire logic wr_req_in,
  input wire logic rd_req_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [7:0] phase_sel_in,
  input wire logic [2:0] phase_count_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  // Non-volatile restore
  input wire logic nvm_restore_in,
  input wire logic [15:0] nvm_limit_in,
  input wire logic [7:0] nvm_response_in,
  // Converter side
  input wire logic oc_trip_in,
  input wire logic pwm_clk_in,
  input wire logic output_on_in,
  input wire logic startup_done_in,
  input wire logic clear_faults_in,
  output logic power_on_out,
  output logic latched_off_out,
  output logic [5*`MAX_PHASES-1:0] hw_limit_amps_out,
  // Status and host notification
  output logic status_byte_iout_oc_out,
  output logic status_word_iout_out,
  output logic status_iout_ocf_out,
  output logic status_cml_data_out,
  output logic alert_n_out
);

  // Linear word to quarter amps; bit 11 flags negative or oversize data
  // Writes round up to the next quarter, a restore rounds to the nearest one
  function automatic logic [11:0] lin_to_q(input logic [15:0] w, input logic nearest);
    logic signed [5:0] sh;
    logic [4:0] n;
    logic [31:0] mag;
    logic [31:0] q;
    logic bad;
    sh = 6'(signed'(w[15:11])) + 6'sd2;
    bad = w[10];
    mag = {21'h0, w[10:0]};
    q = 32'h0;
    n = 5'(-sh);
    if (sh >= 6'sd0) begin
      if (sh > 6'sd20) begin
        bad = bad | (mag != 32'h0);
      end else begin
        q = mag << sh;
      end
    end else if (nearest) begin
      q = (mag + (32'h1 << (n - 5'h1))) >> n;
    end else begin
      q = (mag + (32'h1 << n) - 32'h1) >> n;
    end
    bad = bad | (q > 32'h7FF);
    lin_to_q = {bad, q[10:0]};
  endfunction

  // Pin synchronisers
  // A third flop keeps the last synchronised level for edge finding
  logic trip_s1, trip_s2, trip_prev;
  logic pwm_s1, pwm_s2, pwm_prev;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      trip_s1 <= 1'b0;
      trip_s2 <= 1'b0;
      trip_prev <= 1'b0;
      pwm_s1 <= 1'b0;
      pwm_s2 <= 1'b0;
      pwm_prev <= 1'b0;
    end else if (ce_in) begin
      trip_s1 <= oc_trip_in;
      trip_s2 <= trip_s1;
      trip_prev <= trip_s2;
      pwm_s1 <= pwm_clk_in;
      pwm_s2 <= pwm_s1;
      pwm_prev <= pwm_s2;
    end
  end

  wire trip_rise = trip_s2 & ~trip_prev;
  wire pwm_edge = pwm_s2 & ~pwm_prev;

  // Limit storage, one entry per phase, quarter-amp units
  phase_limit_t phase_limit [`MAX_PHASES];
  logic [4:0] limit_exp;
  logic [7:0] response;

  // Command decode
  wire is_limit = cmd_code_in == `CMD_FAULT_LIMIT;
  wire is_resp = cmd_code_in == `CMD_FAULT_RESPONSE;
  wire stack_sel = phase_sel_in == `PHASE_ALL;
  wire [10:0] n_phases = {8'h0, phase_count_in};
  // A selector at or beyond the phase count is refused for writes
  wire sel_ok = phase_sel_in < {5'h0, phase_count_in};
  wire [1:0] sel_idx = phase_sel_in[1:0];
  wire [11:0] wr_conv = lin_to_q(wr_data_in, 1'b0);
  wire [10:0] wr_q = wr_conv[10:0];
  wire [11:0] nvm_conv = lin_to_q(nvm_limit_in, 1'b1);
  wire [10:0] nvm_q = nvm_conv[10:0];
  wire [21:0] stack_max_wide = `STACK_MAX_Q_PER * n_phases;
  wire [10:0] stack_max = stack_max_wide[10:0];

  wire range_ok = stack_sel ? (wr_q <= stack_max) : (sel_ok && wr_q <= `PHASE_MAX_Q);
  // Small values are accepted as written
  wire limit_ok = ~wr_conv[11] && range_ok && phase_count_in != 3'h0;
  wire [1:0] wr_action = wr_data_in[`ACTION_MSB:`ACTION_LSB];
  wire resp_ok = wr_action != 2'(act_invalid);
  wire limit_wr = ce_in && wr_req_in && is_limit;
  wire resp_wr = ce_in && wr_req_in && is_resp;
  wire bad_write = (limit_wr && !limit_ok) || (resp_wr && !resp_ok);

  // Stack write shares the value among phases
  // Only a three-phase stack needs a real divider; two and four shift
  logic [10:0] share_q;
  always_comb begin
    unique case (phase_count_in)
      3'h2: share_q = wr_q >> 1;
      3'h3: share_q = 11'(wr_q / 11'd3);
      3'h4: share_q = wr_q >> 2;
      default: share_q = wr_q;
    endcase
  end
  wire [6:0] share_sat = (share_q > `PHASE_MAX_Q) ? 7'(`PHASE_MAX_Q) : share_q[6:0];
  // Restore rounds to nearest quarter, capped at 23 A
  wire [6:0] nvm_sat = (nvm_conv[11] || nvm_q > `PHASE_MAX_Q) ? 7'(`PHASE_MAX_Q) : nvm_q[6:0];

  // Per-phase storage and hardware step mapping
  genvar gi;
  generate
    for (gi = 0; gi < `MAX_PHASES; gi++) begin : g_phase
      wire wr_this = limit_wr && limit_ok && (stack_sel || sel_idx == 2'(gi));
      wire [6:0] wr_val = stack_sel ? share_sat : wr_q[6:0];
      wire [6:0] amps_up = (phase_limit[gi] + 7'h3) >> 2;
      wire [4:0] hw_amps = (amps_up[4:0] < `HW_MIN_A) ? `HW_MIN_A : amps_up[4:0];
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
          phase_limit[gi] <= `LIMIT_RST_Q;
          hw_limit_amps_out[5*gi +: 5] <= 5'h00;
        end else if (ce_in) begin
          // Restore wins over a simultaneous write
          if (nvm_restore_in) begin
            phase_limit[gi] <= nvm_sat;
          end else if (wr_this) begin
            // Selected phase takes the value undivided
            phase_limit[gi] <= wr_val;
          end
          // Round up to whole amps, floor 4 A
          // All five bits go out, since the top step is 23 A
          hw_limit_amps_out[5*gi +: 5] <= hw_amps;
        end
      end
    end
  endgenerate

  // Response register
  // Delay bits take writes too, so the stored byte reads back whole
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      limit_exp <= `LIMIT_EXP_RST;
      response <= `RESPONSE_RST;
    end else if (ce_in) begin
      if (nvm_restore_in) begin
        limit_exp <= `LIMIT_EXP_RST;
        response <= nvm_response_in;
      end else if (resp_wr && resp_ok) begin
        response <= wr_data_in[7:0];
      end
    end
  end

  // Read path; other command codes read as zero
  // A stack read scales phase 0 only, so uneven phases are not visible
  wire [10:0] stack_rd = {4'h0, phase_limit[0]} * {8'h0, phase_count_in};
  wire [10:0] rd_man = stack_sel ? stack_rd : {4'h0, phase_limit[sel_idx]};
  wire [15:0] rd_word = is_limit ? {limit_exp, rd_man} : (is_resp ? {8'h00, response} : 16'h0000);
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else if (ce_in) begin
      rd_valid_out <= rd_req_in;
      if (rd_req_in) begin
        rd_data_out <= rd_word;
      end
    end
  end

  // Response field decode
  wire [1:0] action = response[`ACTION_MSB:`ACTION_LSB];
  wire [2:0] retry_limit = response[`RETRY_MSB:`RETRY_LSB];
  wire [2:0] delay_code = response[`DELAY_MSB:`DELAY_LSB];
  wire [2:0] pwm_delay = (delay_code < 3'h2) ? `DELAY_SHORT_PWM :
                         (delay_code < 3'h5) ? `DELAY_MID_PWM : `DELAY_LONG_PWM;
  wire [2:0] hiccup_mult = (delay_code < 3'h2) ? 3'h1 : delay_code;
  wire [31:0] hiccup_wide = 32'(TON_RISE_CYCLES) * {29'h0, hiccup_mult};
  // Seven rise times at the default still fit in 24 bits
  wire [23:0] hiccup_cycles = hiccup_wide[23:0];

  resp_state_e state, next_state;
  logic [2:0] pwm_cnt;
  logic [23:0] hiccup_cnt;
  logic [2:0] attempts;

  // Decide restart or latch off after the hiccup
  wire retry_left = (retry_limit == `RETRY_FOREVER) || (attempts < retry_limit);
  wire shut_now = (state == st_delay && pwm_edge && pwm_cnt == 3'h1);
  wire fault_run = trip_rise && (state == st_run || state == st_restart);

  always_comb begin
    next_state = state;
    unique case (state)
      st_off: if (output_on_in) next_state = st_restart;
      st_run, st_restart: begin
        if (state == st_restart && startup_done_in) next_state = st_run;
        if (fault_run) begin
          if (action == 2'(act_delayed)) begin
            next_state = st_delay;
          end else if (action == 2'(act_immediate)) begin
            next_state = (retry_limit == 3'h0) ? st_latched : st_hiccup;
          end
        end
      end
      st_delay: if (shut_now) next_state = (retry_limit == 3'h0) ? st_latched : st_hiccup;
      st_hiccup: begin
        if (hiccup_cnt == 24'h1) next_state = retry_left ? st_restart : st_latched;
      end
      // Only the off command below leaves the latched state
      st_latched: next_state = st_latched;
      default: next_state = st_off;
    endcase
    if (!output_on_in) next_state = st_off;
  end

  // Enable and latch outputs follow the next state so they leave a flop
  wire drive_on = next_state == st_run || next_state == st_restart || next_state == st_delay;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= st_off;
      power_on_out <= 1'b0;
      latched_off_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      power_on_out <= drive_on;
      latched_off_out <= next_state == st_latched;
    end
  end

  // Shutdown delay counts synchronised switching-clock rising edges
  wire delay_enter = next_state == st_delay && state != st_delay;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pwm_cnt <= 3'h0;
    end else if (ce_in) begin
      if (delay_enter) begin
        pwm_cnt <= pwm_delay;
      end else if (state == st_delay && pwm_edge) begin
        pwm_cnt <= pwm_cnt - 3'h1;
      end
    end
  end

  // Hiccup timer; it may run down harmlessly after an off command
  wire hiccup_enter = next_state == st_hiccup && state != st_hiccup;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      hiccup_cnt <= 24'h0;
    end else if (ce_in) begin
      if (hiccup_enter) begin
        hiccup_cnt <= hiccup_cycles;
      end else if (hiccup_cnt != 24'h0) begin
        hiccup_cnt <= hiccup_cnt - 24'h1;
      end
    end
  end

  // Fresh attempt budget after success or off
  wire attempts_clr = next_state == st_off || (state == st_restart && next_state == st_run);
  // The forever setting never counts, so the three-bit counter cannot wrap
  wire attempts_inc = state == st_hiccup && next_state == st_restart &&
    retry_limit != `RETRY_FOREVER;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      attempts <= 3'h0;
    end else if (ce_in) begin
      if (attempts_clr) begin
        attempts <= 3'h0;
      end else if (attempts_inc) begin
        attempts <= attempts + 3'h1;
      end
    end
  end

  // Sticky status; a new event outranks a clear in the same cycle
  wire oc_event = trip_rise && state != st_off && state != st_latched;
  logic next_oc, next_cml;
  assign next_oc = oc_event | (status_iout_ocf_out & ~clear_faults_in);
  assign next_cml = bad_write | (status_cml_data_out & ~clear_faults_in);
  // Three status bits set together with the alert
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      status_byte_iout_oc_out <= 1'b0;
      status_word_iout_out <= 1'b0;
      status_iout_ocf_out <= 1'b0;
    end else if (ce_in) begin
      status_byte_iout_oc_out <= next_oc;
      status_word_iout_out <= next_oc;
      status_iout_ocf_out <= next_oc;
    end
  end

  // Data fault flag and the shared alert line
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      status_cml_data_out <= 1'b0;
      alert_n_out <= 1'b1;
    end else if (ce_in) begin
      status_cml_data_out <= next_cml;
      alert_n_out <= ~(next_oc | next_cml);
    end
  end

endmodule

// ---- tb/ocl_props.sv ----
// Assertion checker for the overcurrent limit and response command logic
module ocl_props
  import ocl_pkg::*;
(
  // Clock and command side
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic wr_req_in,
  input wire logic rd_req_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] wr_data_in,
  input wire logic [7:0] phase_sel_in,
  input wire logic rd_valid_out,
  // Converter and status side
  input wire logic oc_trip_in,
  input wire logic clear_faults_in,
  input wire logic output_on_in,
  input wire logic power_on_out,
  input wire logic latched_off_out,
  input wire logic status_byte_iout_oc_out,
  input wire logic status_word_iout_out,
  input wire logic status_iout_ocf_out,
  input wire logic status_cml_data_out,
  input wire logic alert_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  wire wr46 = ce_in && wr_req_in && cmd_code_in == 8'h46;
  wire wr47 = ce_in && wr_req_in && cmd_code_in == 8'h47;

  a_read_answer: assert property (ce_in && rd_req_in |=> rd_valid_out)
    else $error("read strobe not answered");
  a_no_stray_valid: assert property (ce_in && !rd_req_in |=> !rd_valid_out)
    else $error("read valid without strobe");
  a_status_tied: assert property (status_byte_iout_oc_out == status_iout_ocf_out &&
    status_word_iout_out == status_iout_ocf_out)
    else $error("status copies disagree");
  a_alert_level: assert property (alert_n_out == !(status_iout_ocf_out || status_cml_data_out))
    else $error("alert does not follow status");
  a_bad_action: assert property (wr47 && wr_data_in[7:6] == 2'h1 |=> status_cml_data_out)
    else $error("invalid action accepted");
  a_phase_range: assert property (wr46 && phase_sel_in == 8'h00 && wr_data_in[15:11] == 5'h1E &&
    wr_data_in[10:0] inside {[11'h05D:11'h3FF]} |=> status_cml_data_out)
    else $error("phase limit above range accepted");
  a_sticky_fault: assert property (status_iout_ocf_out && !clear_faults_in |=> status_iout_ocf_out)
    else $error("fault status dropped");
  a_trip_flags: assert property ($rose(oc_trip_in) && power_on_out |-> ##[2:8] status_iout_ocf_out)
    else $error("trip not flagged");
  a_latch_no_power: assert property (latched_off_out |-> !power_on_out)
    else $error("power on while latched");
  a_latch_holds: assert property (latched_off_out && output_on_in |=> latched_off_out)
    else $error("latched state left while output on");

  c_read: cover property (rd_valid_out);
  c_fault: cover property ($rose(status_iout_ocf_out));
  c_latch: cover property ($rose(latched_off_out));
endmodule

bind overcurrent_fault_limit_response ocl_props chk (.*);

// ---- tb/host_model.sv ----
// Host-side model that issues limit and response commands
module host_model (
  // Command port toward the block
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] cmd_out,
  output logic [15:0] data_out,
  output logic [7:0] sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_out, rd_out, cmd_out, sel_out, data_out} = 34'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] s,
      input logic [15:0] d);
    @(negedge clk_in);
    {wr_out, rd_out, cmd_out, sel_out, data_out} = {w, !w, c, s, d};
    @(negedge clk_in);
    {wr_out, rd_out} = 2'b00;
    // Released data is scrambled so a stale value cannot pass
    data_out = ~d;
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the overcurrent limit and response logic
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in, sys_rst_in, ce_in, wr_req_in, rd_req_in, nvm_restore_in, oc_trip_in;
  logic pwm_clk_in, output_on_in, startup_done_in, clear_faults_in, rd_valid_out;
  logic power_on_out, latched_off_out, status_byte_iout_oc_out, status_word_iout_out;
  logic status_iout_ocf_out, status_cml_data_out, alert_n_out;
  logic [2:0] phase_count_in;
  logic [7:0] cmd_code_in, phase_sel_in, nvm_response_in;
  logic [15:0] wr_data_in, rd_data_out, nvm_limit_in;
  logic [19:0] hw_limit_amps_out;
  logic [15:0] exp_q[$];
  int miscompares, checks_done, q;
  wire [2:0] obs = {latched_off_out, status_iout_ocf_out, power_on_out};
  wire [15:0] hw0 = {11'h000, hw_limit_amps_out[4:0]};
  overcurrent_fault_limit_response #(.TON_RISE_CYCLES(20)) dut (.*);
  host_model host (.clk_in(core_clk_in), .wr_out(wr_req_in), .rd_out(rd_req_in),
    .cmd_out(cmd_code_in), .data_out(wr_data_in), .sel_out(phase_sel_in));
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // Switching clock runs free, out of phase with the core clock
  initial begin
    pwm_clk_in = 1'b0;
    #7;
    forever #100 pwm_clk_in = ~pwm_clk_in;
  end
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge core_clk_in) begin
    if (rd_valid_out === 1'b1) begin
      cmp(rd_data_out, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data_out);
    end
  end
  task automatic rd(input logic [7:0] c, input logic [7:0] s, input logic [15:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, c, s, 16'h0000);
    @(negedge core_clk_in);
  endtask
  task automatic wait_for(input int k, input logic v, input int n);
    for (int i = 0; i < n && obs[k] !== v; i++) begin
      @(negedge core_clk_in);
    end
    cmp({15'h0, obs[k]}, {15'h0, v});
    if (obs[k] !== v) begin
      wrap_up();
    end
  endtask
  task automatic start_up();
    output_on_in = 1'b1;
    wait_for(0, 1'b1, 10);
    startup_done_in = 1'b1;
    @(negedge core_clk_in);
    startup_done_in = 1'b0;
  endtask
  task automatic trip_clear(input logic t);
    {oc_trip_in, clear_faults_in} = {t, !t};
    repeat (4) @(negedge core_clk_in);
    {oc_trip_in, clear_faults_in} = 2'b00;
  endtask
  initial begin
    {ce_in, sys_rst_in, nvm_restore_in, oc_trip_in} = 4'hC;
    {output_on_in, startup_done_in, clear_faults_in} = 3'h0;
    phase_count_in = 3'h2;
    nvm_limit_in = 16'hE0A7;
    nvm_response_in = 8'h8D;
    {miscompares, checks_done} = 0;
    q = $urandom(32'hA3367448);
    repeat (20) @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    @(negedge core_clk_in);
    cmp(hw0, 16'h000A);
    rd(8'h46, 8'h00, 16'hF028);
    nvm_restore_in = 1'b1;
    @(negedge core_clk_in);
    nvm_restore_in = 1'b0;
    rd(8'h46, 8'hFF, 16'hF054);
    rd(8'h47, 8'h00, 16'h008D);
    host.xfer(1'b1, 8'h46, 8'hFF, 16'hF028);
    rd(8'h46, 8'h01, 16'hF014);
    rd(8'h46, 8'hFF, 16'hF028);
    cmp({11'h000, hw_limit_amps_out[9:5]}, 16'h0005);
    phase_count_in = 3'h3;
    host.xfer(1'b1, 8'h46, 8'hFF, 16'hF04B);
    rd(8'h46, 8'h02, 16'hF019);
    rd(8'h46, 8'hFF, 16'hF04B);
    cmp({11'h000, hw_limit_amps_out[14:10]}, 16'h0007);
    phase_count_in = 3'h2;
    repeat (6) begin
      q = 16 + $urandom % 77;
      host.xfer(1'b1, 8'h46, 8'h00, {5'h1E, 11'(q)});
      rd(8'h46, 8'h00, {5'h1E, 11'(q)});
      cmp(hw0, 16'((q + 3) / 4));
    end
    rd(8'h46, 8'h01, 16'hF019);
    host.xfer(1'b1, 8'h46, 8'h00, 16'hF00A);
    rd(8'h46, 8'h00, 16'hF00A);
    cmp(hw0, 16'h0004);
    host.xfer(1'b1, 8'h46, 8'h00, 16'hF060);
    rd(8'h46, 8'h00, 16'hF00A);
    cmp({14'h0, status_cml_data_out, alert_n_out}, 16'h0002);
    host.xfer(1'b1, 8'h47, 8'h00, 16'h0040);
    rd(8'h47, 8'h00, 16'h008D);
    trip_clear(1'b0);
    cmp({14'h0, status_cml_data_out, alert_n_out}, 16'h0001);
    host.xfer(1'b1, 8'h47, 8'h00, 16'h00C0);
    start_up();
    trip_clear(1'b1);
    wait_for(1, 1'b1, 4);
    wait_for(2, 1'b1, 8);
    cmp({14'h0, alert_n_out, power_on_out}, 16'h0000);
    output_on_in = 1'b0;
    wait_for(2, 1'b0, 8);
    trip_clear(1'b0);
    host.xfer(1'b1, 8'h47, 8'h00, 16'h008D);
    start_up();
    trip_clear(1'b1);
    repeat (36) @(negedge core_clk_in);
    cmp({15'h0, power_on_out}, 16'h0001);
    wait_for(0, 1'b0, 40);
    repeat (80) @(negedge core_clk_in);
    cmp({15'h0, power_on_out}, 16'h0000);
    wait_for(0, 1'b1, 60);
    start_up();
    host.xfer(1'b1, 8'h47, 8'h00, 16'h0000);
    trip_clear(1'b1);
    repeat (20) @(negedge core_clk_in);
    cmp({15'h0, power_on_out}, 16'h0001);
    cmp(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule
